// *** logic/svc_defines.svh ***
`ifndef SVC_DEFINES_SVH
`define SVC_DEFINES_SVH

// Gain code 0 is -33 dB, code 15 is +12 dB, 3 dB per code
`define SVC_GAIN_MIN 4'h0
`define SVC_GAIN_MAX 4'hf
`define SVC_GAIN_0DB 4'hb
`define SVC_STEP_DB 3
`define SVC_MIN_DB (-33)

`endif

// *** logic/svc_pkg.sv ***
package svc_pkg;
  typedef logic [3:0] svc_gain_t;
  typedef enum logic [1:0] {
    SVC_HOLD = 2'b00,
    SVC_UP = 2'b01,
    SVC_DOWN = 2'b10
  } svc_step_e;
endpackage

// *** logic/svc_step_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface svc_step_if;
  import svc_pkg::*;
  svc_step_e step;
  svc_gain_t gain;
  modport ctrl (output step, input gain);
  modport cnt (input step, output gain);
endinterface
`default_nettype wire

// *** logic/svc_gain_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "svc_defines.svh"
module svc_gain_counter
  import svc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  svc_step_if.cnt port_s
);

  // Saturating add of one step toward the limit
  function automatic svc_gain_t sat_step(input svc_gain_t g, input svc_step_e s);
    sat_step = g;
    if (s == SVC_UP && g != `SVC_GAIN_MAX) begin
      sat_step = svc_gain_t'(g + 4'h1);
    end else if (s == SVC_DOWN && g != `SVC_GAIN_MIN) begin
      sat_step = svc_gain_t'(g - 4'h1);
    end
  endfunction

  // Power-on only; shutdown never touches this, so the setting survives it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_s.gain <= `SVC_GAIN_0DB;
    end else begin
      port_s.gain <= sat_step(port_s.gain, port_s.step);
    end
  end

  gain_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (port_s.step == SVC_UP && port_s.gain == `SVC_GAIN_MAX) |=> port_s.gain == `SVC_GAIN_MAX)
    else $error("gain wrapped above maximum");
  gain_floor_a: assert property (@(posedge clock) disable iff (!rst_n)
    (port_s.step == SVC_DOWN && port_s.gain == `SVC_GAIN_MIN) |=> port_s.gain == `SVC_GAIN_MIN)
    else $error("gain wrapped below minimum");

endmodule
`default_nettype wire

// *** logic/svc_volume_ctrl.sv ***
// How it works
// - Gain moves by exactly one 3 dB step, only on a rising edge of the volume clock pin.
// - Direction high at that edge raises the gain one step.
// - Direction low at that edge lowers the gain one step.
// - The gain is one of 16 codes; gain_db shows -30 dB up to +12 dB, and code 0 (-33 dB) wraps to +31 there.
// - Power-on puts the gain at the 0 dB code.
// - Leaving shutdown keeps the gain that was set before it.
// - The polarity select pin picks active-high or active-low shutdown.
// - Shutdown holds while the shutdown pin equals the polarity pin.
// - In shutdown the amplifier bias is turned off.
`timescale 1ns/1ps
`default_nettype none
`include "svc_defines.svh"
module svc_volume_ctrl
  import svc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic volume_clock,
  input wire logic step_direction_select,
  input wire logic power_down_request,
  input wire logic power_down_polarity_select,
  output logic [3:0] gain_code,
  output logic signed [5:0] gain_db,
  output logic bias_enable,
  output logic power_down
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] vclk_sync;
  logic [1:0] dir_sync;
  logic [1:0] pdr_sync;
  logic [1:0] pol_sync;
  logic vclk_prev;

  // Only the second stage is read; the first may be metastable.
  // No reset here: the stages follow the pins during reset, so a pin
  // already high at release reaches the edge detector as a level, not an edge.
  always_ff @(posedge clock) begin
    vclk_sync <= {vclk_sync[0], volume_clock};
    dir_sync <= {dir_sync[0], step_direction_select};
    pdr_sync <= {pdr_sync[0], power_down_request};
    pol_sync <= {pol_sync[0], power_down_polarity_select};
  end

  // ****************************************
  // Edge detect
  // ****************************************
  // Starts high so a pin already high at release is not a false edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vclk_prev <= 1'b1;
    end else begin
      vclk_prev <= vclk_sync[1];
    end
  end

  // ****************************************
  // Step decode
  // ****************************************
  logic vclk_rise;
  logic next_power_down;
  svc_step_if step_s ();

  assign vclk_rise = vclk_sync[1] & ~vclk_prev;
  assign next_power_down = (pdr_sync[1] == pol_sync[1]);

  // Direction passes the same two stages as the clock, so both are aligned.
  // Edges during shutdown still count; the counter is digital state only.
  always_comb begin
    step_s.step = SVC_HOLD;
    if (vclk_rise) begin
      if (dir_sync[1]) begin
        step_s.step = SVC_UP;
      end else begin
        step_s.step = SVC_DOWN;
      end
    end
  end

  svc_gain_counter u_counter (
    .clock(clock),
    .rst_n(rst_n),
    .port_s(step_s)
  );

  // ****************************************
  // Outputs
  // ****************************************
  function automatic logic signed [5:0] code_to_db(input svc_gain_t c);
    code_to_db = 6'(`SVC_MIN_DB + `SVC_STEP_DB * int'(c));
  endfunction

  // Code and dB come from the same counter value in the same edge, so they never disagree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gain_code <= `SVC_GAIN_0DB;
    end else begin
      gain_code <= step_s.gain;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gain_db <= 6'h00;
    end else begin
      gain_db <= code_to_db(step_s.gain);
    end
  end

  // ****************************************
  // Shutdown
  // ****************************************
  // Reset stands for power-on, so the amplifier stays unbiased until the pins settle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_down <= 1'b1;
    end else begin
      power_down <= next_power_down;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bias_enable <= 1'b0;
    end else begin
      bias_enable <= ~next_power_down;
    end
  end

  // ****************************************
  // Step checks
  // ****************************************
  // A step seen at one edge reaches the counter one edge later and the pins one more
  step_up_a: assert property (@(posedge clock) disable iff (!rst_n)
    (vclk_rise && dir_sync[1] && step_s.gain != `SVC_GAIN_MAX) |=> ##1 gain_code == $past(step_s.gain, 2) + 4'h1)
    else $error("up step did not raise gain by one");

  step_down_a: assert property (@(posedge clock) disable iff (!rst_n)
    (vclk_rise && !dir_sync[1] && step_s.gain != `SVC_GAIN_MIN) |=> ##1 gain_code == $past(step_s.gain, 2) - 4'h1)
    else $error("down step did not lower gain by one");

  no_edge_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !vclk_rise |=> $stable(step_s.gain))
    else $error("gain moved without a clock edge");

  step_one_a: assert property (@(posedge clock) disable iff (!rst_n)
    (gain_code != $past(gain_code)) |-> (gain_code == $past(gain_code) + 4'h1 || gain_code == $past(gain_code) - 4'h1))
    else $error("gain moved by more than one step");

  gain_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    gain_code == $past(step_s.gain))
    else $error("gain pins do not follow the counter");

  db_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    gain_db == 6'(`SVC_MIN_DB + `SVC_STEP_DB * int'(gain_code)))
    else $error("gain code and dB out of step");

  // ****************************************
  // Shutdown checks
  // ****************************************
  pd_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pdr_sync[1] == pol_sync[1]) |=> power_down)
    else $error("shutdown not entered on level match");

  pd_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pdr_sync[1] != pol_sync[1]) |=> !power_down)
    else $error("shutdown held on level mismatch");

  bias_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    power_down |-> !bias_enable)
    else $error("bias on during shutdown");

  bias_on_a: assert property (@(posedge clock) disable iff (!rst_n)
    !power_down |-> bias_enable)
    else $error("bias off while operating");

  gain_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($fell(power_down) && !$past(vclk_rise, 2) && !$past(vclk_rise, 1)) |-> $stable(gain_code))
    else $error("gain changed on leaving shutdown");

  // ****************************************
  // Reset checks
  // ****************************************
  reset_gain_a: assert property (@(posedge clock)
    !rst_n |=> gain_code == `SVC_GAIN_0DB)
    else $error("reset gain not 0 dB");

  reset_db_a: assert property (@(posedge clock)
    !rst_n |=> gain_db == 6'h00)
    else $error("reset dB value not zero");

  reset_pd_a: assert property (@(posedge clock)
    !rst_n |=> (power_down && !bias_enable))
    else $error("amplifier biased during power-on");

  // ****************************************
  // Covers
  // ****************************************
  up_cover: cover property (@(posedge clock) disable iff (!rst_n) step_s.step == SVC_UP);
  down_cover: cover property (@(posedge clock) disable iff (!rst_n) step_s.step == SVC_DOWN);
  top_cover: cover property (@(posedge clock) disable iff (!rst_n) gain_code == `SVC_GAIN_MAX);
  bottom_cover: cover property (@(posedge clock) disable iff (!rst_n) gain_code == `SVC_GAIN_MIN);
  wake_cover: cover property (@(posedge clock) disable iff (!rst_n) $fell(power_down));

endmodule
`default_nettype wire

// *** tb/svc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module svc_host_model (
  input wire logic clock,
  output logic volume_clock,
  output logic step_direction_select,
  output logic power_down_request,
  output logic power_down_polarity_select
);
  // Shutdown pin parked inactive from the start, never floating
  initial begin
    volume_clock = 1'b0;
    step_direction_select = 1'b0;
    power_down_request = 1'b0;
    power_down_polarity_select = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Clean edges: direction set up early, clock high and low 3 cycles each
  task automatic step(input logic up);
    tick(1);
    step_direction_select = up;
    tick(2);
    volume_clock = 1'b1;
    tick(3);
    volume_clock = 1'b0;
    tick(3);
  endtask
  task automatic shut(input logic req, input logic pol);
    tick(1);
    power_down_polarity_select = pol;
    power_down_request = req;
    tick(6);
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import svc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic volume_clock, step_direction_select, power_down_request, power_down_polarity_select;
  logic [3:0] gain_code;
  logic signed [5:0] gain_db;
  logic bias_enable, power_down;
  int bad_count = 0;
  int tests_run = 0;
  svc_gain_t exp_q[$];
  svc_gain_t model = 4'hb;
  svc_gain_t seen = 4'hb;
  always #2 clock = ~clock;
  svc_host_model host_u (.clock(clock), .volume_clock(volume_clock),
    .step_direction_select(step_direction_select), .power_down_request(power_down_request),
    .power_down_polarity_select(power_down_polarity_select));
  svc_volume_ctrl dut_u (.clock(clock), .rst_n(rst_n), .volume_clock(volume_clock),
    .step_direction_select(step_direction_select), .power_down_request(power_down_request),
    .power_down_polarity_select(power_down_polarity_select), .gain_code(gain_code),
    .gain_db(gain_db), .bias_enable(bias_enable), .power_down(power_down));
  // ****************
  // Checking
  // ****************
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] to_db(input svc_gain_t c);
    return 6'(c) * 6'd3 - 6'd33;
  endfunction
  // Saturated steps push no note, so a stray change shows as an empty queue
  always @(negedge clock) begin
    if (rst_n && gain_code !== seen) begin
      seen = gain_code;
      if (exp_q.size() == 0) check(6'(gain_code), 6'h3f);
      else begin
        check(6'(gain_code), 6'(exp_q[0]));
        check(gain_db, to_db(exp_q.pop_front()));
      end
    end
  end
  task automatic step(input logic up);
    if (up && model != 4'hf) begin
      model++;
      exp_q.push_back(model);
    end else if (!up && model != 4'h0) begin
      model--;
      exp_q.push_back(model);
    end
    host_u.step(up);
  endtask
  task automatic test_done;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'h6500));
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    check(6'(gain_code), 6'hb);
    check(gain_db, 6'h0);
    $display("test power-on default done");
    repeat (6) step(1'b1);
    repeat (18) step(1'b0);
    $display("test limits done");
    repeat (20) step(1'($urandom));
    $display("test random steps done");
    for (int p = 0; p < 2; p++) begin
      host_u.shut(1'(p), 1'(p));
      check({4'h0, power_down, bias_enable}, 6'h2);
      step(1'b1);
      host_u.shut(1'(~p), 1'(p));
      check({4'h0, power_down, bias_enable}, 6'h1);
      check(6'(gain_code), 6'(model));
    end
    $display("test shutdown done");
    host_u.tick(10);
    check(6'(exp_q.size()), 6'h0);
    test_done;
  end
endmodule
`default_nettype wire
